/* core/darc_regs.svh */
// register offsets, field positions, keys and timing counts of the dram area block
`ifndef DARC_REGS_SVH
`define DARC_REGS_SVH

`define DARC_OFS_DCR 4'h0
`define DARC_OFS_RCR 4'h4
`define DARC_OFS_CTL 4'h8
`define DARC_OFS_STAT 4'hc

`define DARC_RST_WORD 16'h0000
`define DARC_RST_CTL 3'h0
`define DARC_DCR_MASK 16'hff00
`define DARC_RCR_MASK 16'h00f0
`define DARC_RCR_KEY 8'h5a

`define DARC_DCR_CW2 15
`define DARC_DCR_RAS_HOLD_LOW 14
`define DARC_DCR_TPC 13
`define DARC_DCR_BE 12
`define DARC_DCR_CAS_DUTY_SELECT 11
`define DARC_DCR_MXE 10
`define DARC_DCR_MXC_HI 9
`define DARC_DCR_MXC_LO 8

`define DARC_RCR_REFRESH_ENABLE 7
`define DARC_RCR_REFRESH_MODE 6
`define DARC_RCR_RLW_HI 5
`define DARC_RCR_RLW_LO 4

`define DARC_CTL_DRAM_ENABLE_BIT 0
`define DARC_CTL_BUS16 1
`define DARC_CTL_RWSEL 2

`define DARC_MXC_8 2'h0
`define DARC_MXC_9 2'h1
`define DARC_MXC_10 2'h2
`define DARC_SHIFT_8 4'h8
`define DARC_SHIFT_9 4'h9
`define DARC_SHIFT_10 4'ha

`define DARC_TC_CYC 20
`define DARC_DUTY_50 50
`define DARC_DUTY_35 35
`define DARC_PCT 100

`endif

/* core/darc_pkg.sv */
// types shared by the dram area block
package darc_pkg;
   typedef logic [15:0] darc_word_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ROW, ST_COL, ST_PRE, ST_RF_CAS, ST_RF_RAS, ST_RF_WAIT, ST_SELF
   } darc_state_t;
endpackage

/* core/darc_wait_cnt.sv */
// state down-counter used for precharge and refresh wait states
`timescale 1ns/100ps
module darc_wait_cnt #(
   parameter int W = 3
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic last
);
   logic [W-1:0] count_r;

   // load wins, otherwise count down to zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_r <= '0;
      end else if (ce) begin
         if (load) begin
            count_r <= load_val;
         end else if (count_r != '0) begin
            count_r <= count_r - W'(1);
         end
      end
   end

   // final state of the loaded run
   assign last = (count_r == W'(1));
endmodule

/* core/darc_top.sv */
// dram area control, refresh control and the dram strobe sequencer
`timescale 1ns/100ps
`include "darc_regs.svh"
module darc_top #(
   parameter int ADDR_W = 28,
   parameter int TC_CYC = `DARC_TC_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic refresh_match,
   output logic refresh_timer_free,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic [ADDR_W-1:0] acc_addr,
   input wire logic acc_hi_byte,
   input wire logic acc_lo_byte,
   output logic acc_done,
   output logic ras_n,
   output logic cas_high_strobe_n,
   output logic cas_low_strobe_n,
   output logic write_high_strobe_n,
   output logic write_low_strobe_n,
   output logic [ADDR_W-1:0] dram_addr,
   output logic self_refresh_active
);
   import darc_pkg::*;

   localparam int TCW = $clog2(TC_CYC + 1);
   localparam int HI50 = (TC_CYC * `DARC_DUTY_50) / `DARC_PCT;
   localparam int HI35 = (TC_CYC * `DARC_DUTY_35) / `DARC_PCT;

   darc_word_t dram_area_control_r;
   darc_word_t refresh_control_r;
   logic [2:0] ctl_r;
   logic [31:0] readdata_nxt;
   darc_state_t state_r, state_nxt;
   logic [TCW-1:0] tc_cnt_r;
   logic [ADDR_W-1:0] last_row_r;
   logic page_open_r, ref_pend_r;
   logic cnt_load, cnt_last;
   logic [2:0] cnt_val;

   // effective settings
   darc_word_t dcr_eff;
   logic dram_enable_bit, bus16, refresh_wait_select;
   logic strobe_scheme_select, ras_hold_low, precharge_count, burst_enable;
   logic cas_duty_select, multiplex_enable;
   logic [1:0] mxc;
   logic refresh_enable, refresh_mode;
   logic [1:0] rlw;
   logic [3:0] shift;
   logic [ADDR_W-1:0] row_now;
   logic row_match, self_req, bus_req, bus_take;
   logic [TCW-1:0] cas_hi_cyc;

   assign dram_enable_bit = ctl_r[`DARC_CTL_DRAM_ENABLE_BIT];
   assign bus16 = ctl_r[`DARC_CTL_BUS16];
   assign refresh_wait_select = ctl_r[`DARC_CTL_RWSEL];
   // dram area control settings fall back to reset values while dram is disabled
   assign dcr_eff = dram_enable_bit ? dram_area_control_r : `DARC_RST_WORD;
   assign strobe_scheme_select = dcr_eff[`DARC_DCR_CW2];
   assign ras_hold_low = dcr_eff[`DARC_DCR_RAS_HOLD_LOW];
   assign precharge_count = dcr_eff[`DARC_DCR_TPC];
   assign burst_enable = dcr_eff[`DARC_DCR_BE];
   assign cas_duty_select = dcr_eff[`DARC_DCR_CAS_DUTY_SELECT];
   assign multiplex_enable = dcr_eff[`DARC_DCR_MXE];
   assign mxc = dcr_eff[`DARC_DCR_MXC_HI:`DARC_DCR_MXC_LO];
   assign refresh_enable = refresh_control_r[`DARC_RCR_REFRESH_ENABLE];
   assign refresh_mode = refresh_control_r[`DARC_RCR_REFRESH_MODE];
   assign rlw = refresh_control_r[`DARC_RCR_RLW_HI:`DARC_RCR_RLW_LO];
   assign self_req = refresh_enable & refresh_mode;

   // shift count, reserved code treated as the 8-bit shift
   always_comb begin
      case (mxc)
         `DARC_MXC_9: shift = `DARC_SHIFT_9;
         `DARC_MXC_10: shift = `DARC_SHIFT_10;
         default: shift = `DARC_SHIFT_8;
      endcase
   end

   // row compare range follows the shift field whatever multiplexing says
   assign row_now = acc_addr >> shift;
   assign row_match = (row_now == last_row_r);
   assign cas_hi_cyc = cas_duty_select ? TCW'(HI35) : TCW'(HI50);

   // bus handshake: one idle wait cycle, then the answer
   assign bus_req = avs_read | avs_write;
   assign bus_take = avs_write & ~avs_waitrequest;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else if (ce) begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
      end
   end

   // read mux, unused bits read zero
   always_comb begin
      readdata_nxt = '0;
      case (avs_address)
         `DARC_OFS_DCR: readdata_nxt[15:0] = dram_area_control_r & `DARC_DCR_MASK;
         `DARC_OFS_RCR: readdata_nxt[15:0] = refresh_control_r & `DARC_RCR_MASK;
         `DARC_OFS_CTL: readdata_nxt[2:0] = ctl_r;
         `DARC_OFS_STAT: readdata_nxt[5:0] = {self_refresh_active, ref_pend_r,
                                              page_open_r, state_r};
         default: readdata_nxt = '0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= '0;
      end else if (ce && avs_read && avs_waitrequest) begin
         avs_readdata <= readdata_nxt;
      end
   end

   // dram area control, upper byte lane only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dram_area_control_r <= `DARC_RST_WORD;
      end else if (ce && bus_take && avs_address == `DARC_OFS_DCR && avs_byteenable[1]) begin
         dram_area_control_r <= avs_writedata[15:0] & `DARC_DCR_MASK;
      end
   end

   // refresh control takes only keyed word writes
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         refresh_control_r <= `DARC_RST_WORD;
      end else if (ce && bus_take && avs_address == `DARC_OFS_RCR &&
                   avs_byteenable[1:0] == 2'h3 &&
                   avs_writedata[15:8] == `DARC_RCR_KEY) begin
         refresh_control_r <= avs_writedata[15:0] & `DARC_RCR_MASK;
      end
   end

   // bus control bits: dram enable, bus width, refresh wait select
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_r <= `DARC_RST_CTL;
      end else if (ce && bus_take && avs_address == `DARC_OFS_CTL && avs_byteenable[0]) begin
         ctl_r <= avs_writedata[2:0];
      end
   end

   // timer is free for interval use while refresh is off
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         refresh_timer_free <= 1'b1;
      end else if (ce) begin
         refresh_timer_free <= ~refresh_enable;
      end
   end

   // pending cbr request, a new match wins over the clear
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_pend_r <= 1'b0;
      end else if (ce) begin
         if (refresh_match && refresh_enable && !refresh_mode) begin
            ref_pend_r <= 1'b1;
         end else if (state_nxt == ST_RF_CAS || !refresh_enable || refresh_mode) begin
            ref_pend_r <= 1'b0;
         end
      end
   end

   // next state of the strobe sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (self_req) begin
               state_nxt = page_open_r ? ST_PRE : ST_RF_CAS;
            end else if (ref_pend_r) begin
               state_nxt = page_open_r ? ST_PRE : ST_RF_CAS;
            end else if (acc_req && !acc_done) begin
               if (page_open_r && burst_enable && row_match) begin
                  state_nxt = ST_COL;
               end else if (page_open_r) begin
                  state_nxt = ST_PRE;
               end else begin
                  state_nxt = ST_ROW;
               end
            end
         end
         ST_ROW: state_nxt = ST_COL;
         ST_COL: begin
            if (tc_cnt_r == TCW'(TC_CYC - 1)) begin
               state_nxt = ras_hold_low ? ST_IDLE : ST_PRE;
            end
         end
         ST_PRE: if (cnt_last) state_nxt = ST_IDLE;
         ST_RF_CAS: state_nxt = self_req ? ST_SELF : ST_RF_RAS;
         ST_RF_RAS: state_nxt = refresh_wait_select ? ST_RF_WAIT : ST_PRE;
         ST_RF_WAIT: if (cnt_last) state_nxt = ST_PRE;
         ST_SELF: if (!self_req) state_nxt = ST_PRE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // wait counter loads on entry to precharge or refresh wait
   always_comb begin
      cnt_load = 1'b0;
      cnt_val = '0;
      if (state_nxt == ST_PRE && state_r != ST_PRE) begin
         cnt_load = 1'b1;
         cnt_val = {1'b0, precharge_count, ~precharge_count};
      end else if (state_nxt == ST_RF_WAIT && state_r != ST_RF_WAIT) begin
         cnt_load = 1'b1;
         cnt_val = {1'b0, rlw} + 3'h1;
      end
   end

   darc_wait_cnt #(
      .W(3)
   ) u_wait (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ce(ce),
      .load(cnt_load),
      .load_val(cnt_val),
      .last(cnt_last)
   );

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // column state cycle count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tc_cnt_r <= '0;
      end else if (ce) begin
         tc_cnt_r <= (state_r == ST_COL && state_nxt == ST_COL) ? tc_cnt_r + TCW'(1) : '0;
      end
   end

   // open page and last row for burst compare
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         page_open_r <= 1'b0;
         last_row_r <= '0;
      end else if (ce) begin
         if (state_r == ST_ROW) begin
            last_row_r <= row_now;
         end
         if (state_r == ST_COL && state_nxt == ST_IDLE) begin
            page_open_r <= 1'b1;
         end else if (state_r == ST_PRE) begin
            page_open_r <= 1'b0;
         end
      end
   end

   // done is high through the last column cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_done <= 1'b0;
      end else if (ce) begin
         acc_done <= (state_r == ST_COL) && (tc_cnt_r == TCW'(TC_CYC - 2));
      end
   end

   // registered dram pins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ras_n <= 1'b1;
         cas_high_strobe_n <= 1'b1;
         cas_low_strobe_n <= 1'b1;
         write_high_strobe_n <= 1'b1;
         write_low_strobe_n <= 1'b1;
         dram_addr <= '0;
         self_refresh_active <= 1'b0;
      end else if (ce) begin
         ras_n <= ~(state_r == ST_ROW || state_r == ST_COL || state_r == ST_RF_RAS ||
                    state_r == ST_RF_WAIT || state_r == ST_SELF ||
                    (state_r == ST_IDLE && page_open_r));
         self_refresh_active <= (state_r == ST_SELF);
         cas_high_strobe_n <= 1'b1;
         cas_low_strobe_n <= 1'b1;
         write_high_strobe_n <= 1'b1;
         write_low_strobe_n <= 1'b1;
         dram_addr <= acc_addr;
         if (state_r == ST_ROW && multiplex_enable) begin
            dram_addr <= row_now;
         end
         if (state_r == ST_RF_CAS || state_r == ST_RF_RAS || state_r == ST_RF_WAIT ||
             state_r == ST_SELF) begin
            cas_high_strobe_n <= ~bus16;
            cas_low_strobe_n <= 1'b0;
         end else if (state_r == ST_COL) begin
            if (!bus16) begin
               cas_low_strobe_n <= ~(tc_cnt_r >= cas_hi_cyc);
               write_low_strobe_n <= ~acc_write;
            end else if (!strobe_scheme_select) begin
               cas_high_strobe_n <= ~(acc_hi_byte && tc_cnt_r >= cas_hi_cyc);
               cas_low_strobe_n <= ~(acc_lo_byte && tc_cnt_r >= cas_hi_cyc);
               write_low_strobe_n <= ~acc_write;
            end else begin
               cas_low_strobe_n <= ~(tc_cnt_r >= cas_hi_cyc);
               write_high_strobe_n <= ~(acc_write && acc_hi_byte);
               write_low_strobe_n <= ~(acc_write && acc_lo_byte);
            end
         end
      end
   end
endmodule

/* test/darc_assertions.sv */
// port checker for the dram area block
`timescale 1ns/100ps
module darc_assertions (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic refresh_match,
   input wire logic refresh_timer_free,
   input wire logic acc_done,
   input wire logic ras_n,
   input wire logic cas_high_strobe_n,
   input wire logic cas_low_strobe_n,
   input wire logic write_high_strobe_n,
   input wire logic self_refresh_active
);
   logic [7:0] dcr_r;
   logic [7:0] rcr_r;
   logic [2:0] ctl_r;
   logic wr_ok;
   logic [7:0] dcr_eff;
   // accepted writes; area settings count only with dram enabled
   assign wr_ok = avs_write && !avs_waitrequest;
   assign dcr_eff = ctl_r[0] ? dcr_r : 8'h00;
   // shadow of the settings as software wrote them
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dcr_r <= 8'h00;
         rcr_r <= 8'h00;
         ctl_r <= 3'h0;
      end else begin
         if (wr_ok && avs_address == 4'h0 && avs_byteenable[1]) dcr_r <= avs_writedata[15:8];
         if (wr_ok && avs_address == 4'h4 && avs_byteenable[1:0] == 2'h3
               && avs_writedata[15:8] == 8'h5a) rcr_r <= {avs_writedata[7:4], 4'h0};
         if (wr_ok && avs_address == 4'h8 && avs_byteenable[0]) ctl_r <= avs_writedata[2:0];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_pre2;
      ras_n [*2];
   endsequence
   property p_rd_dcr;
      avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[7:0] == 8'h00;
   endproperty
   a_rd_dcr: assert property (p_rd_dcr) else $error("dcr low byte not zero");
   property p_rd_rcr;
      avs_read && !avs_waitrequest && avs_address == 4'h4 |-> avs_readdata[15:0] == {8'h00, rcr_r};
   endproperty
   a_rd_rcr: assert property (p_rd_rcr) else $error("refresh control readback");
   property p_free;
      $stable(rcr_r[7]) [*3] |-> refresh_timer_free == !rcr_r[7];
   endproperty
   a_free: assert property (p_free) else $error("timer free flag wrong");
   property p_self;
      $rose(self_refresh_active) |-> rcr_r[7] && rcr_r[6];
   endproperty
   a_self: assert property (p_self) else $error("self refresh without mode");
   property p_cas_high_strobe;
      !rcr_r[7] && (!ctl_r[1] || dcr_eff[7]) |-> cas_high_strobe_n;
   endproperty
   a_cas_high_strobe: assert property (p_cas_high_strobe) else $error("high cas used");
   property p_wrh;
      !rcr_r[7] && (!ctl_r[1] || !dcr_eff[7]) |-> write_high_strobe_n;
   endproperty
   a_wrh: assert property (p_wrh) else $error("high write used");
   property p_pre;
      $rose(ras_n) && dcr_eff[5] |-> s_pre2;
   endproperty
   a_pre: assert property (p_pre) else $error("precharge too short");
   property p_ras_up;
      acc_done && !dcr_eff[6] |-> ##[1:3] ras_n;
   endproperty
   a_ras_up: assert property (p_ras_up) else $error("ras not released");
   property p_ras_dn;
      acc_done && dcr_eff[6] && !rcr_r[7] |=> !ras_n [*3];
   endproperty
   a_ras_dn: assert property (p_ras_dn) else $error("ras not held low");
   property p_cbr;
      refresh_match && rcr_r[7] && !rcr_r[6] |-> ##[1:60] (ras_n && !cas_low_strobe_n);
   endproperty
   a_cbr: assert property (p_cbr) else $error("no cas before ras");
endmodule
bind darc_top darc_assertions darc_assertions_inst (.sys_clk, .rst_b, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .refresh_match, .refresh_timer_free, .acc_done, .ras_n, .cas_high_strobe_n,
   .cas_low_strobe_n, .write_high_strobe_n, .self_refresh_active);

/* test/darc_dram_model.sv */
// dram chip model: latches rows, times cas and counts refreshes
`timescale 1ns/100ps
module darc_dram_model #(
   parameter int ADDR_W = 28
) (
   input wire logic sys_clk,
   input wire logic ras_n,
   input wire logic cas_low_strobe_n,
   input wire logic [ADDR_W-1:0] dram_addr,
   output logic [ADDR_W-1:0] row_q,
   output int gap,
   output int low_len,
   output int cbr_cnt
);
   logic ras_q = 1'b1;
   logic cas_q = 1'b1;
   int run = 0;
   // strobe edges seen on the pins
   always @(posedge sys_clk) begin
      ras_q <= ras_n;
      cas_q <= cas_low_strobe_n;
      if (!ras_n && ras_q) begin
         run <= 1;
         if (!cas_low_strobe_n) cbr_cnt <= cbr_cnt + 1;
         else row_q <= dram_addr;
      end else if (!ras_n) run <= run + 1;
      if (ras_n && !ras_q) low_len <= run;
      if (!ras_n && !cas_low_strobe_n && cas_q) gap <= run;
   end
endmodule

/* test/tb.sv */
// self-checking bench for the dram area block
`timescale 1ns/100ps
module tb;
   localparam int TC = 20;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic refresh_match = 1'b0;
   logic refresh_timer_free;
   logic acc_req = 1'b0;
   logic acc_write = 1'b0;
   logic [27:0] acc_addr = 28'h0;
   logic acc_hi_byte = 1'b1;
   logic acc_lo_byte = 1'b1;
   logic acc_done;
   logic ras_n;
   logic cas_high_strobe_n;
   logic cas_low_strobe_n;
   logic write_high_strobe_n;
   logic write_low_strobe_n;
   logic [27:0] dram_addr;
   logic self_refresh_active;
   logic [27:0] row_q;
   int gap;
   int low_len;
   int cbr_cnt;
   int mismatches = 0;
   int checked = 0;
   logic acc_req_q = 1'b0;
   logic [3:0] lo_seen = 4'h0;
   darc_top #(.ADDR_W(28), .TC_CYC(TC)) darc_top_inst (.sys_clk, .rst_b, .ce, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .refresh_match, .refresh_timer_free, .acc_req, .acc_write, .acc_addr, .acc_hi_byte,
      .acc_lo_byte, .acc_done, .ras_n, .cas_high_strobe_n, .cas_low_strobe_n,
      .write_high_strobe_n, .write_low_strobe_n, .dram_addr, .self_refresh_active);
   darc_dram_model #(.ADDR_W(28)) darc_dram_model_inst (.sys_clk, .ras_n, .cas_low_strobe_n,
      .dram_addr, .row_q, .gap, .low_len, .cbr_cnt);
   // 200 mhz clock
   initial forever #2.5 sys_clk = ~sys_clk;
   // strobes seen low since the access request last rose, {cas_high_strobe, cas_low_strobe, wrh, wrl}
   always @(posedge sys_clk) begin
      acc_req_q <= acc_req;
      if (acc_req && !acc_req_q) begin
         lo_seen <= 4'h0;
      end else begin
         lo_seen <= lo_seen | ~{cas_high_strobe_n, cas_low_strobe_n, write_high_strobe_n,
                                write_low_strobe_n};
      end
   end
   task automatic report_and_stop;
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
         input logic [3:0] be, output logic [31:0] q);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(q, e);
   endtask
   // dram access; lat counts edges until done is seen
   task automatic acc(input logic [27:0] a, input int sp, output int lat);
      lat = 0;
      acc_addr <= a;
      acc_req <= 1'b1;
      do begin
         @(posedge sys_clk);
         lat++;
      end while (acc_done !== 1'b1 && lat < 200);
      if (lat >= 200) mismatches++;
      acc_req <= 1'b0;
      repeat (sp) @(posedge sys_clk);
   endtask
   task automatic pulse;
      refresh_match <= 1'b1;
      @(posedge sys_clk);
      refresh_match <= 1'b0;
      repeat (30) @(posedge sys_clk);
   endtask
   task automatic wait_sr(input logic v);
      int n;
      n = 0;
      while (self_refresh_active !== v && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      chk(self_refresh_active, v);
   endtask
   // watchdog
   initial begin
      #(20000 * 5);
      mismatches++;
      report_and_stop();
   end
   // main sequence
   initial begin
      int l0;
      int h;
      int c0;
      int pl[2];
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      chk(refresh_timer_free, 1'b1);
      rd(4'h1, 32'h0);
      wr(4'h0, 32'hffff_ff00, 4'hf);
      rd(4'h0, 32'h0000_ff00);
      wr(4'h4, 32'h0000_5ab0, 4'hf);
      rd(4'h4, 32'h0000_00b0);
      wr(4'h4, 32'h0000_a500, 4'hf);
      wr(4'h4, 32'h0000_5a00, 4'h1);
      rd(4'h4, 32'h0000_00b0);
      wr(4'h4, 32'h0000_5a00, 4'h3);
      wr(4'h8, 32'h1, 4'hf);
      for (int c = 0; c < 3; c++) begin
         wr(4'h0, {16'h0, 6'h1, c[1:0], 8'h00}, 4'hf);
         acc(28'habc_def1, 6, l0);
         chk(row_q, 28'habc_def1 >> (8 + c));
      end
      wr(4'h0, 32'h0200, 4'hf);
      acc(28'habc_def1, 6, l0);
      chk(row_q, 28'habc_def1);
      wr(4'h8, 32'h0, 4'hf);
      wr(4'h0, 32'h0600, 4'hf);
      acc(28'habc_def1, 6, l0);
      chk(row_q, 28'habc_def1);
      acc_write <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(4'h8, {30'h0, k[0], 1'b1}, 4'hf);
         wr(4'h0, {16'h0, k[1], 15'h0}, 4'hf);
         acc(28'h10, 6, l0);
         chk(lo_seen, k[0] ? (k[1] ? 32'h7 : 32'hd) : 32'h5);
      end
      acc_lo_byte <= 1'b0;
      wr(4'h0, 32'h0, 4'hf);
      acc(28'h10, 6, l0);
      chk(lo_seen, 32'h9);
      wr(4'h0, 32'h8000, 4'hf);
      acc(28'h10, 6, l0);
      chk(lo_seen, 32'h6);
      acc_lo_byte <= 1'b1;
      acc_write <= 1'b0;
      wr(4'h8, 32'h1, 4'hf);
      wr(4'h0, 32'h0, 4'hf);
      acc(28'h20, 6, l0);
      c0 = gap;
      wr(4'h0, 32'h0800, 4'hf);
      acc(28'h20, 6, l0);
      chk(c0 - gap, TC * (50 - 35) / 100);
      for (int t = 0; t < 2; t++) begin
         wr(4'h0, {18'h0, t[0], 13'h0}, 4'hf);
         acc(28'h30, 1, l0);
         acc(28'h40, 6, pl[t]);
      end
      chk(pl[1] - pl[0], 1);
      wr(4'h0, 32'h0, 4'hf);
      c0 = cbr_cnt;
      pulse();
      chk(cbr_cnt, c0);
      wr(4'h4, 32'h5a80, 4'h3);
      pulse();
      chk(cbr_cnt, c0 + 1);
      c0 = low_len;
      wr(4'h4, 32'h5ab0, 4'h3);
      pulse();
      chk(low_len, c0);
      wr(4'h8, 32'h5, 4'hf);
      for (int w = 0; w < 4; w++) begin
         wr(4'h4, {16'h0, 8'h5a, 2'h2, w[1:0], 4'h0}, 4'h3);
         pulse();
         chk(low_len, c0 + w + 1);
      end
      chk(refresh_timer_free, 1'b0);
      wr(4'h4, 32'h5ac0, 4'h3);
      wait_sr(1'b1);
      wr(4'h4, 32'h5a80, 4'h3);
      wait_sr(1'b0);
      wr(4'h4, 32'h5a00, 4'h3);
      wr(4'h8, 32'h1, 4'hf);
      wr(4'h0, 32'h5000, 4'hf);
      acc(28'h1000, 4, l0);
      acc(28'h1004, 4, h);
      chk(l0 - h, 1);
      acc(28'h1104, 4, l0);
      chk(l0 > h, 1'b1);
      wr(4'h0, 32'h5100, 4'hf);
      acc(28'h3000, 4, l0);
      acc(28'h3100, 4, l0);
      chk(l0, h);
      wr(4'h0, 32'h4000, 4'hf);
      acc(28'h3000, 4, l0);
      acc(28'h3000, 4, l0);
      chk(l0 > h, 1'b1);
      chk(refresh_timer_free, 1'b1);
      report_and_stop();
   end
endmodule
